// ---- hdl/rmsp_consts.vh ----
// Constants for the rate meter and set-point output block
`ifndef RMSP_CONSTS_VH
`define RMSP_CONSTS_VH

`define RMSP_CLK_HZ 100000000
`define RMSP_CLK_KHZ 40'h00000186A0
`define RMSP_TICK_MS 10
`define RMSP_GATE_MILLI_MS 1000
`define RMSP_GATE_SEC_MS 500
`define RMSP_GATE_MIN_MS 3000
`define RMSP_GATE_HR_MS 90000

`define RMSP_RANGE_MILLI 2'h0
`define RMSP_RANGE_SEC 2'h1
`define RMSP_RANGE_MIN 2'h2
`define RMSP_RANGE_HR 2'h3

`define RMSP_K_MILLI 11'h3E8
`define RMSP_K_SEC 11'h002
`define RMSP_K_MIN 11'h014
`define RMSP_K_HR 11'h028

`define RMSP_MULT_ONE 20'h02710
`define RMSP_MULT_DIV 64'h0000000000002710
`define RMSP_DISP_MAX 64'h00000000000F423F
`define RMSP_DP_DEFAULT 3'h0
`define RMSP_OFFSET_DEFAULT 32'h00000000

`define RMSP_BMODE_UP 2'h0
`define RMSP_BMODE_DOWN 2'h1
`define RMSP_BMODE_DIR 2'h2

`define RMSP_OMODE_OFF 2'h0
`define RMSP_OMODE_TIMED 2'h1
`define RMSP_OMODE_LATCH 2'h2
`define RMSP_OMODE_BOUND 2'h3

`define RMSP_REL_RESET 2'h0
`define RMSP_REL_UPPER 2'h1
`define RMSP_REL_RESTART 2'h2

`define RMSP_DELAY_MIN 16'h0001
`define RMSP_DELAY_MAX 16'hEA5F

`endif

// ---- hdl/rmsp_core.v ----
// Rate meter and two set-point output channels
//
// Functional notes
// - Milli range: thousandths of Hz, 1.0 s refresh, 1 Hz to 30 kHz.
// - Seconds range: whole Hz, 0.5 s refresh, 2 Hz to 30 kHz.
// - Minutes range: frequency times 60, 3 s refresh, up to 1.2M/min.
// - Hours range: frequency times 3600, 90 s refresh, up to 3.0M/hr.
// - Rate is signed, negative while effective direction is down.
// - B as count input: rate is A plus B, sign from A mode.
// - Rate = truncated(freq x range x multiplier), point placed, plus offset.
// - Intermediate result over six digits is flagged not displayable.
// - Defaults: multiplier 01.0000, point and offset zero, seconds range.
// - Two channels: off, timed, latched or boundary; off is inactive.
// - Timed output fires at trigger, holds 0.01 to 599.99 s.
// - Timed output ignores triggers while its period runs.
// - Reset event cancels a running timed output at once.
// - Latched output fires at trigger, holds until release condition.
// - Release-on-reset: only a reset event releases the latch.
// - Release-on-set-point: count reaching upper value releases the latch.
// - Release-on-restart: count reaching restart value releases the latch.
// - Boundary output active while count lies between low and high.
// - Outputs act regardless of count direction.
// - Output modes default to latched.
// - Upper values are boundary high and latch release values.
// - Set points span -99999 to 999999.
// - B as direction: effective direction is B state xor A direction.
`timescale 1ns/10ps
`include "rmsp_consts.vh"

module rmsp_core #(
    parameter [39:0] GATE_MILLI_CYC = `RMSP_GATE_MILLI_MS * `RMSP_CLK_KHZ,
    parameter [39:0] GATE_SEC_CYC = `RMSP_GATE_SEC_MS * `RMSP_CLK_KHZ,
    parameter [39:0] GATE_MIN_CYC = `RMSP_GATE_MIN_MS * `RMSP_CLK_KHZ,
    parameter [39:0] GATE_HR_CYC = `RMSP_GATE_HR_MS * `RMSP_CLK_KHZ,
    parameter TICK_CYC = `RMSP_TICK_MS * (`RMSP_CLK_HZ / 1000)
) (
    input wire clock,
    input wire arst_n,
    input wire pulse_a,
    input wire pulse_b,
    input wire chan_a_down,
    input wire [1:0] chan_b_mode,
    input wire cfg_load,
    input wire cfg_defaults,
    input wire [1:0] range_mode_in,
    input wire [19:0] rate_mult_in,
    input wire [2:0] rate_point_position_in,
    input wire signed [31:0] rate_offset_in,
    input wire [1:0] output_one_mode_in,
    input wire [1:0] output_two_mode_in,
    input wire [1:0] output_one_release,
    input wire [1:0] output_two_release,
    input wire [15:0] output_one_delay,
    input wire [15:0] output_two_delay,
    input wire signed [31:0] count,
    input wire signed [31:0] count_restart_value,
    input wire signed [31:0] first_trigger_value,
    input wire signed [31:0] first_upper_value,
    input wire signed [31:0] second_trigger_value,
    input wire signed [31:0] second_upper_value,
    input wire reset_event,
    output reg signed [31:0] rate_value,
    output reg rate_valid,
    output reg rate_overflow,
    output wire [2:0] rate_point_position,
    output wire count_down,
    output wire output_one_active,
    output wire output_two_active
);

    reg [1:0] range_reg;
    reg [19:0] mult_reg;
    reg [2:0] point_reg;
    reg signed [31:0] offset_reg;
    reg [1:0] omode1_reg;
    reg [1:0] omode2_reg;
    reg pa_reg;
    reg pb_reg;
    reg [31:0] pulses_reg;
    reg [31:0] pulses_next;
    reg [39:0] gate_reg;
    reg [39:0] gate_len;
    reg [31:0] snap_reg;
    reg snap_valid_reg;
    reg snap_down_reg;
    reg [1:0] snap_range_reg;
    reg [31:0] tick_reg;
    reg tick_pulse_reg;
    reg [10:0] range_k;
    reg [63:0] scaled;
    reg [63:0] trunc;
    reg signed [31:0] signed_int;
    wire rise_a;
    wire rise_b;
    wire b_counts;

    // Setpoint compare; inclusive ends
    function in_band;
        input signed [31:0] val;
        input signed [31:0] lo;
        input signed [31:0] hi;
        begin
            in_band = (val >= lo) && (val <= hi);
        end
    endfunction

    assign rise_a = pulse_a && !pa_reg;
    assign rise_b = pulse_b && !pb_reg;
    assign b_counts = (chan_b_mode == `RMSP_BMODE_UP) ||
                      (chan_b_mode == `RMSP_BMODE_DOWN);
    assign count_down = (chan_b_mode == `RMSP_BMODE_DIR) ?
                        (chan_a_down ^ pulse_b) : chan_a_down;
    assign rate_point_position = point_reg;

    // Configuration store; defaults on reset or request
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            range_reg <= `RMSP_RANGE_SEC;
            mult_reg <= `RMSP_MULT_ONE;
            point_reg <= `RMSP_DP_DEFAULT;
            offset_reg <= `RMSP_OFFSET_DEFAULT;
            omode1_reg <= `RMSP_OMODE_LATCH;
            omode2_reg <= `RMSP_OMODE_LATCH;
        end else if (cfg_defaults) begin
            range_reg <= `RMSP_RANGE_SEC;
            mult_reg <= `RMSP_MULT_ONE;
            point_reg <= `RMSP_DP_DEFAULT;
            offset_reg <= `RMSP_OFFSET_DEFAULT;
            omode1_reg <= `RMSP_OMODE_LATCH;
            omode2_reg <= `RMSP_OMODE_LATCH;
        end else if (cfg_load) begin
            range_reg <= range_mode_in;
            mult_reg <= rate_mult_in;
            point_reg <= rate_point_position_in;
            offset_reg <= rate_offset_in;
            omode1_reg <= output_one_mode_in;
            omode2_reg <= output_two_mode_in;
        end
    end

    // Gate length per range
    always @* begin
        case (range_reg)
            `RMSP_RANGE_MILLI: gate_len = GATE_MILLI_CYC;
            `RMSP_RANGE_SEC: gate_len = GATE_SEC_CYC;
            `RMSP_RANGE_MIN: gate_len = GATE_MIN_CYC;
            default: gate_len = GATE_HR_CYC;
        endcase
    end

    // Pulse count per gate
    always @* begin
        pulses_next = pulses_reg + {31'h00000000, rise_a};
        if (b_counts) begin
            pulses_next = pulses_next + {31'h00000000, rise_b};
        end
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pa_reg <= 1'b0;
            pb_reg <= 1'b0;
            pulses_reg <= 32'h00000000;
            gate_reg <= 40'h0000000000;
            snap_reg <= 32'h00000000;
            snap_valid_reg <= 1'b0;
            snap_down_reg <= 1'b0;
            snap_range_reg <= `RMSP_RANGE_SEC;
        end else begin
            pa_reg <= pulse_a;
            pb_reg <= pulse_b;
            snap_valid_reg <= 1'b0;
            if (cfg_load || cfg_defaults) begin
                gate_reg <= 40'h0000000000;
                pulses_reg <= 32'h00000000;
            end else if (gate_reg >= gate_len - 40'h0000000001) begin
                gate_reg <= 40'h0000000000;
                pulses_reg <= 32'h00000000;
                snap_reg <= pulses_next;
                snap_valid_reg <= 1'b1;
                snap_down_reg <= count_down;
                snap_range_reg <= range_reg;
            end else begin
                gate_reg <= gate_reg + 40'h0000000001;
                pulses_reg <= pulses_next;
            end
        end
    end

    // Pulses per gate times k gives the range-scaled frequency
    always @* begin
        case (snap_range_reg)
            `RMSP_RANGE_MILLI: range_k = `RMSP_K_MILLI;
            `RMSP_RANGE_SEC: range_k = `RMSP_K_SEC;
            `RMSP_RANGE_MIN: range_k = `RMSP_K_MIN;
            default: range_k = `RMSP_K_HR;
        endcase
        scaled = {32'h00000000, snap_reg} * {53'h0, range_k} *
                 {44'h0, mult_reg};
        trunc = scaled / `RMSP_MULT_DIV;
        signed_int = snap_down_reg ? -$signed(trunc[31:0]) :
                     $signed(trunc[31:0]);
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rate_value <= 32'h00000000;
            rate_valid <= 1'b0;
            rate_overflow <= 1'b0;
        end else begin
            rate_valid <= snap_valid_reg;
            if (snap_valid_reg) begin
                rate_value <= signed_int + offset_reg;
                rate_overflow <= (trunc > `RMSP_DISP_MAX);
            end
        end
    end

    // 10 ms tick for output timers
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tick_reg <= 32'h00000000;
            tick_pulse_reg <= 1'b0;
        end else if (tick_reg >= TICK_CYC - 1) begin
            tick_reg <= 32'h00000000;
            tick_pulse_reg <= 1'b1;
        end else begin
            tick_reg <= tick_reg + 32'h00000001;
            tick_pulse_reg <= 1'b0;
        end
    end

    wire [1:0] ch_mode [0:1];
    wire [1:0] ch_rel [0:1];
    wire [15:0] ch_delay [0:1];
    wire signed [31:0] ch_trig [0:1];
    wire signed [31:0] ch_upper [0:1];
    wire [1:0] ch_active;

    assign ch_mode[0] = omode1_reg;
    assign ch_mode[1] = omode2_reg;
    assign ch_rel[0] = output_one_release;
    assign ch_rel[1] = output_two_release;
    assign ch_delay[0] = output_one_delay;
    assign ch_delay[1] = output_two_delay;
    assign ch_trig[0] = first_trigger_value;
    assign ch_trig[1] = second_trigger_value;
    assign ch_upper[0] = first_upper_value;
    assign ch_upper[1] = second_upper_value;
    assign output_one_active = ch_active[0];
    assign output_two_active = ch_active[1];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
            reg active_reg;
            reg [15:0] remain_reg;
            wire hit_trig;
            wire [15:0] load_val;
            // Equality only: direction of approach does not matter
            assign hit_trig = (count == ch_trig[gi]);
            assign load_val = (ch_delay[gi] < `RMSP_DELAY_MIN) ?
                `RMSP_DELAY_MIN : ((ch_delay[gi] > `RMSP_DELAY_MAX) ?
                `RMSP_DELAY_MAX : ch_delay[gi]);
            assign ch_active[gi] = active_reg;

            always @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    active_reg <= 1'b0;
                    remain_reg <= 16'h0000;
                end else begin
                    case (ch_mode[gi])
                        `RMSP_OMODE_TIMED: begin
                            if (reset_event) begin
                                active_reg <= 1'b0;
                                remain_reg <= 16'h0000;
                            end else if (active_reg) begin
                                // Running period ignores triggers
                                if (tick_pulse_reg) begin
                                    remain_reg <= remain_reg - 16'h0001;
                                    if (remain_reg == `RMSP_DELAY_MIN) begin
                                        active_reg <= 1'b0;
                                    end
                                end
                            end else if (hit_trig) begin
                                active_reg <= 1'b1;
                                remain_reg <= load_val;
                            end
                        end
                        `RMSP_OMODE_LATCH: begin
                            remain_reg <= 16'h0000;
                            if (active_reg) begin
                                case (ch_rel[gi])
                                    `RMSP_REL_UPPER: begin
                                        if (count == ch_upper[gi]) begin
                                            active_reg <= 1'b0;
                                        end
                                    end
                                    `RMSP_REL_RESTART: begin
                                        if (count == count_restart_value)
                                        begin
                                            active_reg <= 1'b0;
                                        end
                                    end
                                    default: begin
                                        if (reset_event) begin
                                            active_reg <= 1'b0;
                                        end
                                    end
                                endcase
                            end else if (hit_trig &&
                                !(reset_event &&
                                  ch_rel[gi] == `RMSP_REL_RESET)) begin
                                active_reg <= 1'b1;
                            end
                        end
                        `RMSP_OMODE_BOUND: begin
                            remain_reg <= 16'h0000;
                            active_reg <= in_band(count, ch_trig[gi],
                                                  ch_upper[gi]);
                        end
                        default: begin
                            active_reg <= 1'b0;
                            remain_reg <= 16'h0000;
                        end
                    endcase
                end
            end
        end
    endgenerate

endmodule // rmsp_core

// ---- sim/rmsp_checker_properties.sv ----
// Port-level assertions for the rate meter and set-point outputs
`timescale 1ns/10ps
`include "rmsp_consts.vh"
module rmsp_checker (
    input wire clock,
    input wire arst_n,
    input wire pulse_b,
    input wire chan_a_down,
    input wire [1:0] chan_b_mode,
    input wire cfg_load,
    input wire cfg_defaults,
    input wire [2:0] rate_point_position_in,
    input wire [1:0] output_one_mode_in,
    input wire [1:0] output_two_mode_in,
    input wire [15:0] output_one_delay,
    input wire signed [31:0] count,
    input wire signed [31:0] count_restart_value,
    input wire signed [31:0] first_trigger_value,
    input wire signed [31:0] first_upper_value,
    input wire signed [31:0] second_trigger_value,
    input wire signed [31:0] second_upper_value,
    input wire reset_event,
    input wire [2:0] rate_point_position,
    input wire count_down,
    input wire output_one_active,
    input wire output_two_active
);
default clocking cb @(posedge clock);
endclocking
default disable iff (!arst_n);
// Mode copies, trusted only once a load or a defaults request was seen
reg [3:0] m_reg;
reg known_reg;
wire on = known_reg && !cfg_load && !cfg_defaults;
wire in1 = first_trigger_value <= count && count <= first_upper_value;
wire in2 = second_trigger_value <= count && count <= second_upper_value;
wire rel1 = count == first_upper_value || count == count_restart_value;
wire trig1 = count == first_trigger_value && !reset_event;
always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        known_reg <= 1'h0;
        m_reg <= 4'h0;
    end else if (cfg_defaults) begin
        known_reg <= 1'h1;
        m_reg <= {`RMSP_OMODE_LATCH, `RMSP_OMODE_LATCH};
    end else if (cfg_load) begin
        known_reg <= 1'h1;
        m_reg <= {output_two_mode_in, output_one_mode_in};
    end
end
a_dp_load: assert property (cfg_load && !cfg_defaults |=>
    rate_point_position == $past(rate_point_position_in))
    else $error("point position not loaded");
a_dir_xor: assert property (count_down ==
    ((chan_b_mode == `RMSP_BMODE_DIR) ? chan_a_down ^ pulse_b : chan_a_down))
    else $error("wrong count direction");
a_off_quiet: assert property (on && m_reg[1:0] == `RMSP_OMODE_OFF
    |=> !output_one_active) else $error("disabled output active");
a_bound_one: assert property (on && m_reg[1:0] == `RMSP_OMODE_BOUND
    |=> output_one_active == $past(in1)) else $error("boundary one wrong");
a_bound_two: assert property (on && m_reg[3:2] == `RMSP_OMODE_BOUND
    |=> output_two_active == $past(in2)) else $error("boundary two wrong");
a_latch_set: assert property (on && m_reg[1:0] == `RMSP_OMODE_LATCH
    && trig1 && !rel1 |=> output_one_active) else $error("latch not set");
a_latch_hold: assert property (on && m_reg[1:0] == `RMSP_OMODE_LATCH
    && output_one_active && !rel1 && !reset_event |=> output_one_active)
    else $error("latch dropped early");
a_timed_start: assert property (on && m_reg[1:0] == `RMSP_OMODE_TIMED
    && !output_one_active && trig1 && output_one_delay > 16'h0001
    |=> output_one_active) else $error("timed output not started");
a_timed_cancel: assert property (on && m_reg[1:0] == `RMSP_OMODE_TIMED
    && reset_event |=> !output_one_active) else $error("timed not cancelled");
endmodule // rmsp_checker

// ---- sim/rmsp_pulse_src.sv ----
// Pulse source model feeding one count input
`timescale 1ns/10ps
module rmsp_pulse_src (
    input wire clock,
    input wire en,
    input wire hold,
    input wire [7:0] half,
    output reg pulse = 1'h0
);
reg [7:0] cnt_reg = 8'h00;
// Idle source shows the hold level; period is twice half
always @(negedge clock) begin
    if (!en) begin
        cnt_reg <= 8'h00;
        pulse <= hold;
    end else if (cnt_reg + 8'h01 >= half) begin
        cnt_reg <= 8'h00;
        pulse <= ~pulse;
    end else begin
        cnt_reg <= cnt_reg + 8'h01;
    end
end
endmodule // rmsp_pulse_src

// ---- sim/tb_rmsp_core.sv ----
// Self-checking bench for the rate meter and set-point outputs
`timescale 1ns/10ps
`include "rmsp_consts.vh"
module tb_rmsp_core;
localparam GM = 100;
localparam GS = 50;
localparam GN = 300;
localparam GH = 9000;
reg clock = 1'h0, arst_n = 1'h0, cfg_load = 1'h0, cfg_defaults = 1'h0;
reg reset_event = 1'h0, chan_a_down = 1'h0, en_b = 1'h0, lvl_b = 1'h0;
reg [7:0] half_a = 8'h05;
reg [1:0] chan_b_mode = `RMSP_BMODE_DIR, rm = 2'h1, om = 2'h2, rel = 2'h0;
reg [19:0] mult = 20'h02710;
reg [2:0] dp_in = 3'h3;
reg [15:0] dly = 16'h0003;
reg signed [31:0] off = 32'h0, count = 32'h0, rst_val = -32'sh7;
reg signed [31:0] trig = 32'hA, upper = 32'h14, exp_r;
wire pulse_a, pulse_b, count_down, act1, act2, r_valid, r_ovf;
wire signed [31:0] r_val;
wire [2:0] dp_out;
integer failures = 0, n_checks = 0, i;
rmsp_core #(.GATE_MILLI_CYC(GM), .GATE_SEC_CYC(GS), .GATE_MIN_CYC(GN),
    .GATE_HR_CYC(GH), .TICK_CYC(10)) rmsp_core_inst (.clock(clock),
    .arst_n(arst_n), .pulse_a(pulse_a), .pulse_b(pulse_b),
    .chan_a_down(chan_a_down), .chan_b_mode(chan_b_mode),
    .cfg_load(cfg_load), .cfg_defaults(cfg_defaults), .range_mode_in(rm),
    .rate_mult_in(mult), .rate_point_position_in(dp_in),
    .rate_offset_in(off), .output_one_mode_in(om), .output_two_mode_in(om),
    .output_one_release(rel), .output_two_release(rel),
    .output_one_delay(dly), .output_two_delay(dly), .count(count),
    .count_restart_value(rst_val), .first_trigger_value(trig),
    .first_upper_value(upper), .second_trigger_value(trig),
    .second_upper_value(upper), .reset_event(reset_event),
    .rate_value(r_val), .rate_valid(r_valid), .rate_overflow(r_ovf),
    .rate_point_position(dp_out), .count_down(count_down),
    .output_one_active(act1), .output_two_active(act2));
rmsp_pulse_src src_a_inst (.clock(clock), .en(arst_n), .hold(1'h0),
    .half(half_a), .pulse(pulse_a));
rmsp_pulse_src src_b_inst (.clock(clock), .en(en_b), .hold(lvl_b),
    .half(8'h05), .pulse(pulse_b));
task chk(input [31:0] got, input [31:0] exp);
begin
    n_checks = n_checks + 1;
    if (got !== exp) begin
        failures = failures + 1;
        $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
    end
end
endtask
task report_and_stop;
begin
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
        $display("[ PASS ]");
    end else begin
        $display("[ FAIL ]");
    end
    $finish;
end
endtask
task ld(input [1:0] r, input [19:0] m, input [31:0] o, input [1:0] md);
begin
    rm = r;
    mult = m;
    off = o;
    om = md;
    cfg_load = 1'h1;
    @(negedge clock);
    cfg_load = 1'h0;
end
endtask
// Third result is checked; the second is the first one fully inside the new settings
task rate3;
integer k;
begin
    repeat (3) begin
        k = 0;
        while (r_valid !== 1'h1) begin
            @(negedge clock);
            k = k + 1;
            if (k > 20000) begin
                failures = failures + 1;
                report_and_stop;
            end
        end
        @(negedge clock);
        chk(r_valid, 1'h0);
    end
end
endtask
task step(input [31:0] c, input [31:0] e);
begin
    count = c;
    @(negedge clock);
    chk(act1, e);
    chk(act2, e);
end
endtask
initial begin
    forever #5 clock = ~clock;
end
initial begin
    repeat (16) @(negedge clock);
    arst_n = 1'h1;
    cfg_defaults = 1'h1;
    @(negedge clock);
    cfg_defaults = 1'h0;
    chk(dp_out, 3'h0);
    step(trig, 1'h1);
    step(upper, 1'h1);
    reset_event = 1'h1;
    step(32'h0, 1'h0);
    reset_event = 1'h0;
    for (i = 0; i < 4; i = i + 1) begin
        ld(i[1:0], 20'h02710, 32'h0, `RMSP_OMODE_LATCH);
        chk(dp_out, dp_in);
        exp_r = (i == 0) ? GM / 10 * 1000 : (i == 1) ? GS / 10 * 2 :
            (i == 2) ? GN / 10 * 20 : GH / 10 * 40;
        rate3;
        chk(r_val, exp_r);
    end
    // Scale 0.3333, offset 100: 10 Hz gives 3.333, truncated to 3
    chan_a_down = 1'h1;
    ld(`RMSP_RANGE_SEC, 20'h00D05, 32'h64, `RMSP_OMODE_OFF);
    rate3;
    chk(r_val, 32'h61);
    lvl_b = 1'h1;
    repeat (2) @(negedge clock);
    chk(count_down, 1'h0);
    rate3;
    chk(r_val, 32'h67);
    chan_a_down = 1'h0;
    chan_b_mode = `RMSP_BMODE_UP;
    en_b = 1'h1;
    rate3;
    chk(r_val, 32'h6A);
    chan_b_mode = `RMSP_BMODE_DOWN;
    rate3;
    chk(r_val, 32'h6A);
    en_b = 1'h0;
    chan_b_mode = `RMSP_BMODE_DIR;
    lvl_b = 1'h0;
    half_a = 8'h01;
    ld(`RMSP_RANGE_MILLI, 20'hFFFFF, 32'h0, `RMSP_OMODE_OFF);
    rate3;
    chk(r_ovf, 1'h1);
    ld(`RMSP_RANGE_MILLI, 20'h02710, 32'h0, `RMSP_OMODE_OFF);
    rate3;
    chk(r_ovf, 1'h0);
    chk(r_val, GM / 2 * 1000);
    step(trig, 1'h0);
    ld(`RMSP_RANGE_SEC, 20'h02710, 32'h0, `RMSP_OMODE_BOUND);
    step(32'h9, 1'h0);
    step(trig, 1'h1);
    step(upper, 1'h1);
    step(32'h15, 1'h0);
    step(upper, 1'h1);
    step(32'h0, 1'h0);
    rel = `RMSP_REL_UPPER;
    ld(`RMSP_RANGE_SEC, 20'h02710, 32'h0, `RMSP_OMODE_LATCH);
    step(32'hB, 1'h0);
    step(trig, 1'h1);
    step(32'hF, 1'h1);
    step(upper, 1'h0);
    rel = `RMSP_REL_RESTART;
    step(trig, 1'h1);
    step(upper, 1'h1);
    step(rst_val, 1'h0);
    ld(`RMSP_RANGE_SEC, 20'h02710, 32'h0, `RMSP_OMODE_TIMED);
    step(trig, 1'h1);
    count = 32'h0;
    repeat (17) @(negedge clock);
    step(trig, 1'h1);
    count = 32'h0;
    repeat (13) @(negedge clock);
    chk(act1, 1'h0);
    chk(act2, 1'h0);
    step(trig, 1'h1);
    reset_event = 1'h1;
    step(32'h0, 1'h0);
    reset_event = 1'h0;
    report_and_stop;
end
endmodule // tb_rmsp_core
bind rmsp_core rmsp_checker rmsp_checker_inst (.*);
